// >>> hdl/sst_pkg.sv
// shared constants, register map and types of the i2c slave stretch/timeout controller
package sst_pkg;

   // ==========================================
   // timing
   localparam int unsigned CLK_HZ      = 125_000_000;
   localparam int unsigned TIMEOUT_MS  = 30;
   localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int          TO_W        = 22;

   // ==========================================
   // register map (byte addresses)
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_IRQ  = 8'h08;
   localparam logic [7:0] OFF_MASK = 8'h0C;
   localparam logic [7:0] OFF_ADDR = 8'h10;
   localparam logic [7:0] OFF_DATA = 8'h14;

   // ==========================================
   // reset values and field masks
   localparam logic [15:0] CTRL_RST     = 16'h0001;
   localparam logic [15:0] CTRL_FREE    = 16'h3C00;
   localparam logic [15:0] CTRL_RESTR   = 16'h0331;
   localparam logic [15:0] STAT_SW_CLR  = 16'h01BF;
   localparam logic [15:0] FLAG_BITS    = 16'h03BF;
   localparam logic [6:0]  ADDR1_RST    = 7'h50;
   localparam logic [6:0]  ADDR2_RST    = 7'h51;
   localparam logic [6:0]  ADDR3_RST    = 7'h52;
   localparam logic [6:0]  ADDR4_RST    = 7'h53;
   localparam logic [7:0]  GC_BYTE      = 8'h00;
   localparam logic [3:0]  BIT_FIRST    = 4'h0;
   localparam logic [3:0]  BIT_EIGHTH   = 4'h7;
   localparam logic [3:0]  BIT_ACK      = 4'h8;

   // ==========================================
   // types
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ADDR = 2'b01,
      ST_RX   = 2'b10,
      ST_TX   = 2'b11
   } sst_state_e;

   typedef struct packed {
      logic [1:0] rsv_15_14;
      logic       fourth_address_enable;
      logic       third_address_enable;
      logic       second_address_enable;
      logic       smbus_mode;
      logic       stretch_enable;
      logic       general_call_enable;
      logic [1:0] rsv_7_6;
      logic       ack_value;
      logic       stretch_point_select;
      logic       rsv_3;
      logic       transfer_direction;
      logic       rsv_1;
      logic       slave_enable;
   } sst_ctrl_s;

   typedef struct packed {
      logic       bus_busy_flag;
      logic       transfer_busy;
      logic [2:0] rsv_13_11;
      logic       scl_level;
      logic       overrun_flag;
      logic       general_call_flag;
      logic       nack_flag;
      logic       rsv_6;
      logic       addr_match_flag;
      logic       timeout_flag;
      logic       stretch_flag;
      logic       rx_flag;
      logic       tx_flag;
      logic       start_flag;
   } sst_stat_s;

endpackage

// >>> hdl/sst_slave_ctrl.sv
// i2c target controller: stretching, ack drive, smbus timeout, wishbone registers
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps

// What this block does
// R01: with stretch_enable set, scl is held low at the end of each byte, after clock 8 or 9, except after clock 9 of a transmitted byte that got nack.
// R02: stretch_point_select low stretches after the 9th falling edge, high after the 8th.
// R03: while stretching, stretch_flag is set and scl stays low until software writes it to zero.
// R04: when receiving, the ack value is driven from the 8th falling edge and held through a stretch.
// R05: scl low for more than 30 ms sets timeout_flag, which can raise the interrupt.
// R06: the timeout counter is cleared while scl is high, idle, smbus_mode is off or disabled.
// R07: after a start the counter runs while scl is low; addressing another target returns to idle.
// R08: smbus_mode enables the timeout function and clearing it disables that function.
// R09: writing slave_enable to zero frees sda and scl and returns the engine to idle.
// R10: restricted control fields and slave_enable only accept writes while transfer_busy is zero.
// R11: control bits 13, 12 and 11 enable the fourth, third and second target address.
// R12: general_call_enable makes the target answer the all-zero address, else it ignores it.
// R13: as receiver the target sends nack for ack_value one or a full receive buffer, and ack otherwise.
// R14: transfer_direction takes the read/write bit after a successful address match.
// R15: stretch_point_select has no effect while stretch_enable is clear.
// R16: bus_busy_flag sets on start, clears on stop, on reset and while disabled.
// R17: the timeout interval is a count of system clocks given by a terminal count parameter.
module sst_slave_ctrl #(
   parameter int unsigned TIMEOUT_CYC = sst_pkg::TIMEOUT_CYC
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // interrupt
   output logic             irq,
   // i2c pins, open drain
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe
);
   import sst_pkg::*;

   // ==========================================
   // declarations
   sst_ctrl_s        ctrl_reg;
   sst_stat_s        stat_reg;
   sst_stat_s        set_ev;
   sst_state_e       st_reg;
   logic [3:0]       cnt_reg;
   logic [7:0]       sh_reg;
   logic [7:0]       tx_byte_reg;
   logic [7:0]       rx_byte_reg;
   logic             rx_full_reg;
   logic             nack_seen_reg;
   logic             busy_reg;
   logic             bus_busy_reg;
   logic             sda_oe_reg;
   logic [TO_W-1:0]  to_cnt_reg;
   logic [15:0]      irq_ev_reg;
   logic [15:0]      mask_reg;
   logic             irq_reg;
   logic             ack_reg;
   logic [31:0]      dat_reg;
   logic [6:0]       slv_addr_reg [4];
   logic             scl_s1, scl_s2, scl_d;
   logic             sda_s1, sda_s2, sda_d;
   logic             scl_rise, scl_fall, start_det, stop_det;
   logic             en, acc, wr, rd_take;
   logic [15:0]      bmask;
   logic [3:0]       aen;
   logic [3:0]       hit_vec;
   logic             gc_hit, addr_hit;
   logic             end8, end9, stretch_set, to_run, to_hit;
   logic             rx_done, tx_ack_smp;
   logic [31:0]      addr_rd;

   // ==========================================
   // pin synchronisers and bus conditions
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d  <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d  <= 1'b1;
      end else begin
         scl_s1 <= scl_i;
         scl_s2 <= scl_s1;
         scl_d  <= scl_s2;
         sda_s1 <= sda_i;
         sda_s2 <= sda_s1;
         sda_d  <= sda_s2;
      end
   end

   assign scl_rise  = scl_s2 & ~scl_d;
   assign scl_fall  = ~scl_s2 & scl_d;
   assign start_det = scl_s2 & scl_d & ~sda_s2 & sda_d;
   assign stop_det  = scl_s2 & scl_d & sda_s2 & ~sda_d;
   assign en        = ctrl_reg.slave_enable;

   // ==========================================
   // address match
   assign aen = {ctrl_reg.fourth_address_enable, ctrl_reg.third_address_enable, // R11
                 ctrl_reg.second_address_enable, 1'b1};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_addr
         assign hit_vec[gi] = aen[gi] & (sh_reg[7:1] == slv_addr_reg[gi]); // R11
         assign addr_rd[gi*8 +: 8] = {1'b0, slv_addr_reg[gi]};
      end
   endgenerate
   assign gc_hit   = ctrl_reg.general_call_enable & (sh_reg == GC_BYTE); // R12
   assign addr_hit = (|hit_vec) | gc_hit;

   // byte boundaries: falling edge of clock 8 and of clock 9
   assign end8 = scl_fall & (cnt_reg == BIT_EIGHTH) &
                 ((st_reg == ST_RX) | (st_reg == ST_TX) | ((st_reg == ST_ADDR) & addr_hit));
   assign end9 = scl_fall & (cnt_reg == BIT_ACK) & (st_reg != ST_IDLE) &
                 ~((st_reg == ST_TX) & nack_seen_reg);
   assign stretch_set = en & ctrl_reg.stretch_enable & // R01 R15
                        (ctrl_reg.stretch_point_select ? end8 : end9); // R02
   assign rx_done    = scl_fall & (cnt_reg == BIT_EIGHTH) & (st_reg == ST_RX);
   assign tx_ack_smp = scl_rise & (cnt_reg == BIT_ACK) & (st_reg == ST_TX);

   // ==========================================
   // bus engine
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         st_reg        <= ST_IDLE;
         cnt_reg       <= BIT_FIRST;
         sh_reg        <= GC_BYTE;
         sda_oe_reg    <= 1'b0;
         busy_reg      <= 1'b0;
         nack_seen_reg <= 1'b0;
      end else if (!en) begin
         st_reg     <= ST_IDLE; // R09
         cnt_reg    <= BIT_FIRST;
         sda_oe_reg <= 1'b0; // R09
         busy_reg   <= 1'b0;
      end else if (start_det) begin
         st_reg     <= ST_ADDR; // R07
         cnt_reg    <= BIT_FIRST - 4'h1; // the start's own scl fall wraps it to the first bit
         sda_oe_reg <= 1'b0;
         busy_reg   <= 1'b0;
      end else if (stop_det) begin
         st_reg     <= ST_IDLE;
         sda_oe_reg <= 1'b0;
         busy_reg   <= 1'b0;
      end else if (st_reg != ST_IDLE) begin
         if (scl_rise) begin
            if (cnt_reg != BIT_ACK) begin
               sh_reg <= {sh_reg[6:0], sda_s2};
            end
            if ((cnt_reg == BIT_FIRST) && (st_reg != ST_ADDR)) begin
               busy_reg <= 1'b1;
            end
            if (tx_ack_smp) begin
               nack_seen_reg <= sda_s2;
            end
         end
         if (scl_fall) begin
            if (cnt_reg == BIT_EIGHTH) begin
               cnt_reg <= BIT_ACK;
               case (st_reg)
                  ST_ADDR: begin
                     if (addr_hit) begin
                        sda_oe_reg <= 1'b1;
                     end else begin
                        st_reg <= ST_IDLE; // R07
                     end
                  end
                  ST_RX:   sda_oe_reg <= ~(ctrl_reg.ack_value | rx_full_reg); // R04 R13
                  default: sda_oe_reg <= 1'b0;
               endcase
            end else if (cnt_reg == BIT_ACK) begin
               cnt_reg  <= BIT_FIRST;
               busy_reg <= 1'b0;
               case (st_reg)
                  ST_ADDR: begin
                     if (sh_reg[0]) begin
                        st_reg     <= ST_TX;
                        sh_reg     <= tx_byte_reg;
                        sda_oe_reg <= ~tx_byte_reg[7];
                     end else begin
                        st_reg     <= ST_RX;
                        sda_oe_reg <= 1'b0;
                     end
                  end
                  ST_TX: begin
                     if (nack_seen_reg) begin
                        st_reg     <= ST_IDLE;
                        sda_oe_reg <= 1'b0;
                     end else begin
                        sh_reg     <= tx_byte_reg;
                        sda_oe_reg <= ~tx_byte_reg[7];
                     end
                  end
                  default: sda_oe_reg <= 1'b0;
               endcase
            end else begin
               cnt_reg <= cnt_reg + 4'h1;
               if (st_reg == ST_TX) begin
                  sda_oe_reg <= ~sh_reg[7];
               end
            end
         end
      end
   end

   // ==========================================
   // bus busy
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         bus_busy_reg <= 1'b0; // R16
      end else if (!en || stop_det) begin
         bus_busy_reg <= 1'b0; // R16
      end else if (start_det) begin
         bus_busy_reg <= 1'b1; // R16
      end
   end

   // ==========================================
   // smbus timeout counter
   assign to_run = en & ctrl_reg.smbus_mode & (st_reg != ST_IDLE) & ~scl_s2; // R06 R07 R08
   assign to_hit = to_run & (to_cnt_reg == TO_W'(TIMEOUT_CYC)); // R05 R17

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         to_cnt_reg <= '0;
      end else if (!to_run) begin
         to_cnt_reg <= '0; // R06
      end else if (to_cnt_reg != TO_W'(TIMEOUT_CYC)) begin
         to_cnt_reg <= to_cnt_reg + TO_W'(1); // R17
      end
   end

   // ==========================================
   // wishbone slave
   assign acc     = wb_cyc_i & wb_stb_i & ack_reg;
   assign wr      = acc & wb_we_i;
   assign rd_take = wb_cyc_i & wb_stb_i & ~ack_reg & ~wb_we_i;
   assign bmask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ack_reg <= 1'b0;
         dat_reg <= '0;
      end else begin
         ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
         if (rd_take) begin
            case (wb_adr_i)
               OFF_CTRL: dat_reg <= {16'h0000, ctrl_reg};
               OFF_STAT: dat_reg <= {16'h0000, bus_busy_reg, busy_reg, 3'h0, scl_s2,
                                     stat_reg[9:0]};
               OFF_IRQ:  dat_reg <= {16'h0000, irq_ev_reg};
               OFF_MASK: dat_reg <= {16'h0000, mask_reg};
               OFF_ADDR: dat_reg <= addr_rd;
               OFF_DATA: dat_reg <= {24'h000000, rx_byte_reg};
               default:  dat_reg <= '0;
            endcase
         end
      end
   end

   // ==========================================
   // control register
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ctrl_reg <= sst_ctrl_s'(CTRL_RST);
      end else begin
         if (wr && (wb_adr_i == OFF_CTRL)) begin
            ctrl_reg <= sst_ctrl_s'((ctrl_reg & ~(bmask & (busy_reg ? CTRL_FREE : // R10
                         (CTRL_FREE | CTRL_RESTR)))) | (wb_dat_i[15:0] & bmask &
                         (busy_reg ? CTRL_FREE : (CTRL_FREE | CTRL_RESTR))));
         end
         if (scl_fall && (cnt_reg == BIT_EIGHTH) && (st_reg == ST_ADDR) && addr_hit && en) begin
            ctrl_reg.transfer_direction <= sh_reg[0]; // R14
         end
      end
   end

   // ==========================================
   // target addresses and data buffer
   generate
      for (gi = 0; gi < 4; gi++) begin : g_aw
         always_ff @(posedge ref_clk) begin
            if (!rstn) begin
               slv_addr_reg[gi] <= (gi == 0) ? ADDR1_RST : (gi == 1) ? ADDR2_RST :
                                   (gi == 2) ? ADDR3_RST : ADDR4_RST;
            end else if (wr && (wb_adr_i == OFF_ADDR) && wb_sel_i[gi]) begin
               slv_addr_reg[gi] <= wb_dat_i[gi*8 +: 7];
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         tx_byte_reg <= '0;
         rx_byte_reg <= '0;
         rx_full_reg <= 1'b0;
      end else begin
         if (wr && (wb_adr_i == OFF_DATA) && wb_sel_i[0]) begin
            tx_byte_reg <= wb_dat_i[7:0];
         end
         if (rx_done && !rx_full_reg) begin
            rx_byte_reg <= sh_reg;
            rx_full_reg <= 1'b1;
         end else if (rd_take && (wb_adr_i == OFF_DATA)) begin
            rx_full_reg <= 1'b0;
         end
      end
   end

   // ==========================================
   // status flags and interrupt
   always_comb begin
      set_ev                   = '0;
      set_ev.start_flag        = en & start_det;
      set_ev.addr_match_flag   = en & scl_fall & (cnt_reg == BIT_EIGHTH) &
                                 (st_reg == ST_ADDR) & (|hit_vec);
      set_ev.general_call_flag = en & scl_fall & (cnt_reg == BIT_EIGHTH) &
                                 (st_reg == ST_ADDR) & gc_hit; // R12
      set_ev.rx_flag           = en & rx_done & ~rx_full_reg;
      set_ev.overrun_flag      = en & rx_done & rx_full_reg;
      set_ev.tx_flag           = en & tx_ack_smp;
      set_ev.nack_flag         = en & tx_ack_smp & sda_s2;
      set_ev.timeout_flag      = to_hit; // R05
      set_ev.stretch_flag      = stretch_set; // R03
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         stat_reg <= '0;
      end else if (!en) begin
         stat_reg <= '0; // R09
      end else begin
         stat_reg <= sst_stat_s'((stat_reg & ~((wr && (wb_adr_i == OFF_STAT)) ? // R03
                     (bmask & ~wb_dat_i[15:0] & STAT_SW_CLR) : 16'h0000) &
                     ~((rd_take && (wb_adr_i == OFF_DATA)) ? 16'h0200 : 16'h0000)) |
                     set_ev);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         irq_ev_reg <= '0;
         mask_reg   <= '0;
         irq_reg    <= 1'b0;
      end else begin
         irq_ev_reg <= ((rd_take && (wb_adr_i == OFF_IRQ)) ? 16'h0000 : irq_ev_reg) |
                       (set_ev & FLAG_BITS);
         if (wr && (wb_adr_i == OFF_MASK)) begin
            mask_reg <= ((mask_reg & ~bmask) | (wb_dat_i[15:0] & bmask)) & FLAG_BITS;
         end
         irq_reg <= |(irq_ev_reg & mask_reg); // R05
      end
   end

   // ==========================================
   // outputs
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign irq      = irq_reg;
   assign scl_o    = 1'b0;
   assign sda_o    = 1'b0;
   assign scl_oe   = stat_reg.stretch_flag; // R03
   assign sda_oe   = sda_oe_reg;

   // ==========================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   chk_stretch_needs_en: assert property ($rose(stat_reg.stretch_flag) |-> // R15
      $past(ctrl_reg.stretch_enable)) else $error("stretch without stretch_enable");
   chk_stretch_point: assert property ($rose(stat_reg.stretch_flag) && en |-> // R02
      (cnt_reg == (ctrl_reg.stretch_point_select ? BIT_ACK : BIT_FIRST)))
      else $error("stretch at wrong clock");
   chk_stretch_hold: assert property (stat_reg.stretch_flag && !wr |=> // R03
      scl_oe || !en) else $error("scl released while flag set");
   chk_ack_drive: assert property ($past(rx_done) && en && !start_det && !stop_det // R13
      && $past(en) |-> sda_oe == ~($past(ctrl_reg.ack_value) | $past(rx_full_reg)))
      else $error("ack value not driven");
   chk_ack_held: assert property (st_reg == ST_RX && cnt_reg == BIT_ACK && scl_oe // R04
      && !stop_det && !start_det && en |=> $stable(sda_oe)) else $error("ack moved in stretch");
   chk_timeout_fire: assert property (to_run && to_cnt_reg == TO_W'(TIMEOUT_CYC) // R05
      |=> stat_reg.timeout_flag || !en) else $error("timeout flag missing");
   chk_timeout_idle: assert property (!to_run |=> to_cnt_reg == '0) // R06
      else $error("timer not held reset");
   chk_disable_frees: assert property (!en |=> !scl_oe && !sda_oe && !bus_busy_reg // R09
      && st_reg == ST_IDLE) else $error("disable did not release bus");
   chk_busy_locks_en: assert property (wr && wb_adr_i == OFF_CTRL && busy_reg |=> // R10
      $stable(ctrl_reg.slave_enable)) else $error("enable written while busy");
   chk_bus_busy_start: assert property (en && start_det |=> bus_busy_reg) // R16
      else $error("bus busy not set on start");

endmodule

// >>> sim/sst_i2c_master.sv
// bus master model for the i2c target, open-drain lines with pull-ups
`timescale 1ns/1ps
module sst_i2c_master (
   // shared line levels
   input  wire logic scl,
   input  wire logic sda,
   // pull-downs, high pulls the line low
   output logic      scl_drv,
   output logic      sda_drv
);
   initial begin
      scl_drv = 1'b0;
      sda_drv = 1'b0;
   end
   // ====================
   // bus conditions
   task automatic start();
      #16 sda_drv = 1'b1;
      #16 scl_drv = 1'b1;
   endtask
   task automatic stop();
      #16 sda_drv = 1'b1;
      #16 scl_drv = 1'b0;
      wait (scl === 1'b1);
      #16 sda_drv = 1'b0;
      #16;
   endtask
   // ====================
   // one 64 ns bit, high phase waits out a stretch
   task automatic bit_io(input logic b, output logic r);
      #16 sda_drv = ~b;
      #16 scl_drv = 1'b0;
      wait (scl === 1'b1);
      #16 r = sda;
      #16 scl_drv = 1'b1;
   endtask
   task automatic byte_io(input logic [7:0] d, input logic ak, output logic [7:0] q,
                          output logic ar);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(ak, ar);
   endtask
   // clock held low for a span
   task automatic low(input int ns);
      scl_drv = 1'b1;
      #(ns);
   endtask
endmodule

// >>> sim/tb_i2c_slave_stretch_timeout_ctrl.sv
// self-checking bench: registers, address match, ack, stretching, timeout
`timescale 1ns/1ps
module tb_i2c_slave_stretch_timeout_ctrl;
   import sst_pkg::*;
   localparam int TO = 200;
   logic        ref_clk, rstn, cyc, stb, we, a1, a2;
   logic [7:0]  adr, d, q;
   logic [31:0] dat, r32;
   logic [15:0] ctrl_m;
   wire  [31:0] dat_o;
   wire         ack, irq, scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda;
   // line levels settle just off the clock edge
   wire #1      scl_w = !(scl_oe | m_scl);
   wire #1      sda_w = !(sda_oe | m_sda);
   int          num_errors, total_checks, nrise, nstr;

   sst_slave_ctrl #(.TIMEOUT_CYC(TO)) dut_u (
      .ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .irq(irq), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe(sda_oe));
   sst_i2c_master m (.scl(scl_w), .sda(sda_w), .scl_drv(m_scl), .sda_drv(m_sda));

   always #4 ref_clk = ~ref_clk;
   always @(posedge scl_w) nrise++;
   always @(posedge scl_oe) nstr++;

   // ====================
   // bus access and compares
   task automatic complete_run();
      if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] v,
                     output logic [31:0] r);
      int n;
      @(posedge ref_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {16'h0000, v};
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'b1 && n < 64);
      if (n == 64) begin
         num_errors++;
         $display("unexpected at %0t: no bus ack", $time);
      end
      r = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      wb(1'b1, a, v, r32);
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [15:0] mk, input logic [15:0] e);
      logic [31:0] r;
      repeat (4) @(posedge ref_clk);
      wb(1'b0, a, 16'h0000, r);
      total_checks++;
      if ((r & {16'h0000, mk}) !== {16'h0000, e & mk}) begin
         num_errors++;
         $display("unexpected at %0t: reg %h read %h", $time, a, r);
      end
   endtask
   task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   function automatic logic exp_ack(input logic [6:0] a);
      if (a == 7'h00) return ctrl_m[8];
      if (a == 7'h50) return 1'b1;
      return ctrl_m[10 + a - 7'h50];
   endfunction
   // stretch seen: position, ack drive, hold, release
   task automatic stretch_wait(input int s, input int idx);
      int n;
      n = 0;
      while (scl_oe !== 1'b1 && n < 3000) begin
         @(posedge ref_clk);
         n++;
      end
      chk_val(16'(n < 3000), 16'h0001);
      @(posedge ref_clk);
      chk_val(16'(nrise), 16'(9 * idx + 9 - s));
      chk_val(sda_oe, 16'(s));
      repeat (40) @(posedge ref_clk);
      chk_reg(OFF_STAT, 16'h4008, (s == 1 && idx == 1) ? 16'h4008 : 16'h0008);
      chk_val(scl_oe, 1'b1);
      if (s == 1 && idx == 1) begin
         wr(OFF_CTRL, 16'h0800);
         chk_reg(OFF_CTRL, 16'h3B31, 16'h0A11);
      end
      wr(OFF_STAT, 16'hFFF7);
      repeat (3) @(posedge ref_clk);
      chk_val(scl_oe, 1'b0);
   endtask

   // ====================
   // scenarios
   initial begin
      ref_clk = 1'b0; rstn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
      adr = 8'h00; dat = 32'h0000_0000;
      num_errors = 0; total_checks = 0; nrise = 0; nstr = 0;
      void'($urandom(84));
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      chk_reg(OFF_CTRL, 16'hFFFF, CTRL_RST);
      chk_reg(OFF_STAT, 16'hFFFF, 16'h0400);
      chk_reg(8'h18, 16'hFFFF, 16'h0000);
      chk_val({14'h0000, scl_o, sda_o}, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         ctrl_m = 16'($urandom) & 16'h3900 | 16'h0001;
         wr(OFF_CTRL, ctrl_m);
         for (int j = 0; j < 5; j++) begin
            d = (j == 4) ? 8'h00 : {7'h50 + 7'(j), 1'b0};
            m.start();
            chk_reg(OFF_STAT, 16'h8000, 16'h8000);
            m.byte_io(d, 1'b1, q, a1);
            chk_val(a1, !exp_ack(d[7:1]));
            m.stop();
            chk_reg(OFF_STAT, 16'h8000, 16'h0000);
         end
      end
      d = 8'($urandom);
      wr(OFF_CTRL, 16'h0001);
      wr(OFF_DATA, {8'h00, d});
      m.start();
      m.byte_io(8'hA1, 1'b1, q, a1);
      m.byte_io(8'hFF, 1'b1, q, a2);
      m.stop();
      chk_val({7'h00, a1, q}, {8'h00, d});
      chk_reg(OFF_CTRL, 16'h0004, 16'h0004);
      for (int v = 0; v < 2; v++) begin
         d = 8'($urandom);
         wr(OFF_CTRL, 16'h0011 | 16'(v << 5));
         m.start();
         m.byte_io(8'hA0, 1'b1, q, a1);
         m.byte_io(d, 1'b1, q, a2);
         m.stop();
         chk_val({a1, a2}, 16'(v));
         chk_reg(OFF_CTRL, 16'h0004, 16'h0000);
         chk_reg(OFF_DATA, 16'h00FF, {8'h00, d});
      end
      chk_val(16'(nstr), 16'h0000);
      for (int s = 0; s < 2; s++) begin
         d = 8'($urandom);
         wr(OFF_CTRL, 16'h0201 | 16'(s << 4));
         nrise = 0;
         fork
            begin
               m.start();
               m.byte_io(8'hA0, 1'b1, q, a1);
               m.byte_io(d, 1'b1, q, a2);
               m.stop();
            end
            begin
               stretch_wait(s, 0);
               stretch_wait(s, 1);
            end
         join
         chk_val({a1, a2}, 16'h0000);
         chk_reg(OFF_DATA, 16'h00FF, {8'h00, d});
      end
      fork
         begin
            m.start();
            m.byte_io(8'hA0, 1'b1, q, a1);
         end
         begin
            wait (scl_oe === 1'b1);
            wr(OFF_CTRL, 16'h0200);
            repeat (3) @(posedge ref_clk);
            chk_val(scl_oe, 1'b0);
            chk_reg(OFF_STAT, 16'hFBFF, 16'h0000);
            wr(OFF_CTRL, 16'h0001);
         end
      join
      m.stop();
      wr(OFF_MASK, 16'h0010);
      for (int c = 0; c < 5; c++) begin
         wr(OFF_CTRL, (c == 3) ? 16'h0001 : 16'h0401);
         wr(OFF_STAT, 16'h0000);
         wb(1'b0, OFF_IRQ, 16'h0000, r32);
         if (c > 0) begin
            m.start();
            m.byte_io((c == 2) ? 8'h60 : 8'hA0, 1'b1, q, a1);
         end
         m.low((c == 4) ? 150 * 8 : 300 * 8);
         chk_reg(OFF_STAT, 16'h0010, (c == 1) ? 16'h0010 : 16'h0000);
         chk_val(irq, 16'(c == 1));
         m.stop();
         chk_reg(OFF_IRQ, 16'h0010, (c == 1) ? 16'h0010 : 16'h0000);
         repeat (2) @(posedge ref_clk);
         chk_val(irq, 1'b0);
      end
      complete_run();
   end

   initial begin
      #400_000;
      num_errors++;
      complete_run();
   end
endmodule
